// [core/dgp_gpio.v]
// Behaviour
// - Direction bit one makes the pin an output; zero makes it an input.
// - An output pin is driven with its data latch bit.
// - Data writes with byte lane 0 strobed update the latch in either direction; input pins do not show it.
// - Ordinary data read of an output pin returns the latch bit.
// - Ordinary data read of an input pin returns the sampled pin level.
// - Read-modify-write reads return the latch bit whatever the pin does.
// - Peripheral input pins keep direction zero; data reads still show pin level.
// - Reset clears all first-port direction bits, so every pin is an input.
// - Standby with pin-state bit set floats pins and blocks inputs low.
// - Trigger pin input stays live in standby when both interrupt enables set.
// - Standby with pin-state bit clear leaves pins and outputs unchanged.
// - Pull-up enable bit one connects the pull-up; zero disconnects it.
// - A pin driving low always has its pull-up disconnected.
// - Register bits 0 to 3 map to the four pins; upper bits unused.
// - Second port has four interrupt-capable pins with the same controls.
// - Interrupt-enabled second-port pins are exempt from the standby input block.
// - Second-port pin levels feed the external interrupt outputs in either direction, except where the standby input block forces them low.
// - Reset clears all second-port direction bits too.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dgp_map.vh"

module dgp_gpio #(
  parameter PINS = 4
) (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire [7:0]          s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [7:0]          s_axi_araddr,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  input  wire                standby_req,
  input  wire [2*PINS-1:0]   pin_i,
  output reg  [2*PINS-1:0]   pin_o,
  output reg  [2*PINS-1:0]   pin_oe,
  output reg  [2*PINS-1:0]   pullup_en,
  output reg                 ppg0_trigger_input,
  output reg                 adc_trigger_input,
  output reg  [PINS-1:0]     ext_irq_in
);

  localparam NP = 2 * PINS;

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [PINS-1:0] port8_output_latch_q;
  reg  [PINS-1:0] port8_direction_ctl_q;
  reg  [PINS-1:0] port8_pullup_ctl_q;
  reg  [PINS-1:0] irqport_output_latch_q;
  reg  [PINS-1:0] irqport_direction_ctl_q;
  reg  [PINS-1:0] irqport_pullup_ctl_q;
  reg             standby_pin_state_bit_q;
  reg  [5:0]      irq_enable_q;

  // ****************************************************************
  // Write channel holding
  // ****************************************************************
  reg             aw_hold_q;
  reg  [7:0]      aw_addr_q;
  reg             w_hold_q;
  reg  [7:0]      w_data_q;
  reg             w_strb_q;
  wire            do_write;
  reg             wr_hit;

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  reg  [NP-1:0]   pin_meta_q;
  reg  [NP-1:0]   pin_sync_q;
  wire [NP-1:0]   latch_all;
  wire [NP-1:0]   dir_all;
  wire [NP-1:0]   pul_all;
  wire [NP-1:0]   exempt;
  wire [NP-1:0]   pin_eff;
  wire [NP-1:0]   ordinary_view;
  wire [NP-1:0]   oe_d;
  wire [NP-1:0]   pul_d;
  wire            forced_hiz;

  // Every pin arrives asynchronously, so two flops guard all logic.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= {NP{1'b0}};
      pin_sync_q <= {NP{1'b0}};
    end else begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign latch_all  = {irqport_output_latch_q, port8_output_latch_q};
  assign dir_all    = {irqport_direction_ctl_q, port8_direction_ctl_q};
  assign pul_all    = {irqport_pullup_ctl_q, port8_pullup_ctl_q};
  assign forced_hiz = standby_req & standby_pin_state_bit_q;

  // ****************************************************************
  // Per-pin logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
      if (gi == `DGP_TRIG_PIN) begin : g_trig
        // Both the channel enable and the pin selection must agree.
        assign exempt[gi] = irq_enable_q[`DGP_IRQEN_CH0_BIT] &
                            irq_enable_q[`DGP_IRQEN_SEL_BIT];
      end else if (gi >= PINS) begin : g_irq
        assign exempt[gi] = irq_enable_q[`DGP_IRQEN_PORT_LSB + gi - PINS];
      end else begin : g_plain
        assign exempt[gi] = 1'b0;
      end
      // Blocked inputs read low to avoid a floating input leaking.
      assign pin_eff[gi] = (forced_hiz & ~exempt[gi]) ? 1'b0 : pin_sync_q[gi];
      assign ordinary_view[gi] = dir_all[gi] ? latch_all[gi] : pin_eff[gi];
      assign oe_d[gi] = dir_all[gi] & ~forced_hiz;
      // A low output would fight the pull-up, so it is cut off.
      assign pul_d[gi] = pul_all[gi] & ~(oe_d[gi] & ~latch_all[gi]);
    end
  endgenerate

  // ****************************************************************
  // Pin side outputs
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_o              <= {NP{1'b0}};
      pin_oe             <= {NP{1'b0}};
      pullup_en          <= {NP{1'b0}};
      ppg0_trigger_input <= 1'b0;
      adc_trigger_input  <= 1'b0;
      ext_irq_in         <= {PINS{1'b0}};
    end else begin
      pin_o              <= latch_all;
      pin_oe             <= oe_d;
      pullup_en          <= pul_d;
      ppg0_trigger_input <= pin_eff[`DGP_TRIG_PIN];
      adc_trigger_input  <= pin_eff[`DGP_TRIG_PIN];
      // Fed regardless of direction; software disables unused channels.
      ext_irq_in         <= pin_eff[NP-1:PINS];
    end
  end

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  always @* begin
    wr_hit = 1'b0;
    case (aw_addr_q)
      `DGP_OFF_P8_LATCH: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_P8_DIR: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_P8_PULLUP: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_IRQ_LATCH: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_IRQ_DIR: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_IRQ_PULLUP: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_STANDBY_CTL: begin
        wr_hit = 1'b1;
      end
      `DGP_OFF_IRQ_ENABLE: begin
        wr_hit = 1'b1;
      end
      // The read-modify-write views are read-only, so writes to them are refused.
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DGP_RESP_OKAY;
      aw_hold_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_hold_q      <= 1'b0;
      w_data_q      <= 8'h00;
      w_strb_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        w_data_q     <= s_axi_wdata[7:0];
        w_strb_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      port8_output_latch_q    <= `DGP_RST_LATCH;
      port8_direction_ctl_q   <= `DGP_RST_DIR;
      port8_pullup_ctl_q      <= `DGP_RST_PULLUP;
      irqport_output_latch_q  <= `DGP_RST_LATCH;
      irqport_direction_ctl_q <= `DGP_RST_DIR;
      irqport_pullup_ctl_q    <= `DGP_RST_PULLUP;
      standby_pin_state_bit_q <= `DGP_RST_SPL;
      irq_enable_q            <= `DGP_RST_IRQEN;
    end else if (do_write && w_strb_q) begin
      // Only byte lane 0 carries a register; upper lanes are ignored.
      case (aw_addr_q)
        `DGP_OFF_P8_LATCH: begin
          port8_output_latch_q <= w_data_q[PINS-1:0];
        end
        `DGP_OFF_P8_DIR: begin
          port8_direction_ctl_q <= w_data_q[PINS-1:0];
        end
        `DGP_OFF_P8_PULLUP: begin
          port8_pullup_ctl_q <= w_data_q[PINS-1:0];
        end
        `DGP_OFF_IRQ_LATCH: begin
          irqport_output_latch_q <= w_data_q[PINS-1:0];
        end
        `DGP_OFF_IRQ_DIR: begin
          irqport_direction_ctl_q <= w_data_q[PINS-1:0];
        end
        `DGP_OFF_IRQ_PULLUP: begin
          irqport_pullup_ctl_q <= w_data_q[PINS-1:0];
        end
        `DGP_OFF_STANDBY_CTL: begin
          standby_pin_state_bit_q <= w_data_q[`DGP_STBY_SPL_BIT];
        end
        `DGP_OFF_IRQ_ENABLE: begin
          irq_enable_q <= w_data_q[5:0];
        end
        default: begin
          irq_enable_q <= irq_enable_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  reg  [7:0] rd_byte;
  reg        rd_hit;
  wire [7:0] ar_word;

  assign ar_word = {s_axi_araddr[7:2], 2'b00};

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (ar_word)
      `DGP_OFF_P8_LATCH: begin
        rd_byte = {4'h0, ordinary_view[PINS-1:0]};
      end
      `DGP_OFF_P8_DIR: begin
        rd_byte = {4'h0, port8_direction_ctl_q};
      end
      `DGP_OFF_P8_PULLUP: begin
        rd_byte = {4'h0, port8_pullup_ctl_q};
      end
      `DGP_OFF_IRQ_LATCH: begin
        rd_byte = {4'h0, ordinary_view[NP-1:PINS]};
      end
      `DGP_OFF_IRQ_DIR: begin
        rd_byte = {4'h0, irqport_direction_ctl_q};
      end
      `DGP_OFF_IRQ_PULLUP: begin
        rd_byte = {4'h0, irqport_pullup_ctl_q};
      end
      `DGP_OFF_STANDBY_CTL: begin
        rd_byte = {7'h00, standby_pin_state_bit_q};
      end
      `DGP_OFF_IRQ_ENABLE: begin
        rd_byte = {2'b00, irq_enable_q};
      end
      // Alias windows stand in for the read half of a read-modify-write.
      `DGP_OFF_P8_LATCH_RMW: begin
        rd_byte = {4'h0, port8_output_latch_q};
      end
      `DGP_OFF_IRQ_LATCH_RMW: begin
        rd_byte = {4'h0, irqport_output_latch_q};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DGP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dgp_gpio

// [core/dgp_map.vh]
`ifndef DGP_MAP_VH
`define DGP_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DGP_OFF_P8_LATCH     8'h00
`define DGP_OFF_P8_DIR       8'h04
`define DGP_OFF_P8_PULLUP    8'h08
`define DGP_OFF_IRQ_LATCH    8'h0C
`define DGP_OFF_IRQ_DIR      8'h10
`define DGP_OFF_IRQ_PULLUP   8'h14
`define DGP_OFF_STANDBY_CTL  8'h18
`define DGP_OFF_IRQ_ENABLE   8'h1C
`define DGP_OFF_P8_LATCH_RMW 8'h20
`define DGP_OFF_IRQ_LATCH_RMW 8'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define DGP_STBY_SPL_BIT     0
`define DGP_IRQEN_PORT_LSB   0
`define DGP_IRQEN_PORT_MSB   3
`define DGP_IRQEN_CH0_BIT    4
`define DGP_IRQEN_SEL_BIT    5
`define DGP_TRIG_PIN         3

// ****************************************************************
// Reset values
// ****************************************************************
`define DGP_RST_LATCH        4'h0
`define DGP_RST_DIR          4'h0
`define DGP_RST_PULLUP       4'h0
`define DGP_RST_SPL          1'b0
`define DGP_RST_IRQEN        6'h00

// ****************************************************************
// Bus answers
// ****************************************************************
`define DGP_RESP_OKAY        2'b00
`define DGP_RESP_SLVERR      2'b10

`endif

// [dv/dgp_gpio_props.sv]
`timescale 1ns/1ps
module dgp_gpio_props #(
  parameter PINS = 4
) (
  input wire logic              aclk, aresetn, standby_req,
  input wire logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic              s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [2*PINS-1:0] pin_i, pin_o, pin_oe, pullup_en,
  input wire logic              ppg0_trigger_input, adc_trigger_input,
  input wire logic [PINS-1:0]   ext_irq_in
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_pullup_cut: assert property ((pullup_en & pin_oe & ~pin_o) == 8'h00)
    else $error("pull-up on a low output");
  // Five stable samples cover the three-flop pin path even at the edge after reset.
  a_level_follow: assert property ((!standby_req && $stable(pin_i)) [*5]
    |-> ext_irq_in == pin_i[2*PINS-1:PINS] && ppg0_trigger_input == pin_i[3])
    else $error("peripheral level wrong");
  a_trig_pair: assert property (ppg0_trigger_input == adc_trigger_input)
    else $error("trigger copies differ");
  // Drive changes only through a completed write or a standby edge.
  a_oe_cause: assert property ($changed(pin_oe)
    |-> s_axi_bvalid || $past(s_axi_bvalid)
    || $past(standby_req) != $past(standby_req, 2) || $changed(standby_req))
    else $error("drive changed without cause");
endmodule // dgp_gpio_props

bind dgp_gpio dgp_gpio_props #(.PINS(PINS)) u_dgp_gpio_props (.aclk, .aresetn, .standby_req,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rdata,
  .pin_i, .pin_o, .pin_oe, .pullup_en, .ppg0_trigger_input, .adc_trigger_input, .ext_irq_in);

// [dv/dgp_gpio_test.sv]
`timescale 1ns/1ps
module dgp_gpio_test;
  logic        aclk = 1'b0, aresetn = 1'b0, standby_req = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_val = 8'hAD, ext_en = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, ext_irq_in;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ppg0_trigger_input, adc_trigger_input;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pin_i, pin_o, pin_oe, pullup_en;
  int          err_count = 0, comparisons = 0;
  typedef struct packed {
    logic [7:0] en, wa, wd;
    logic [1:0] er;
    logic [7:0] ra, rv, oe, pu;
  } dgp_row_t;
  dgp_row_t rows [9] = '{
    '{8'hFF, 8'h00, 8'h0A, 2'b00, 8'h00, 8'h0D, 8'h00, 8'h00},
    '{8'hFF, 8'h40, 8'hFF, 2'b10, 8'h20, 8'h0A, 8'h00, 8'h00},
    '{8'hF0, 8'h04, 8'hFF, 2'b00, 8'h04, 8'h0F, 8'h0F, 8'h00},
    '{8'hF0, 8'h00, 8'h03, 2'b00, 8'h00, 8'h03, 8'h0F, 8'h00},
    '{8'hF0, 8'h20, 8'h00, 2'b10, 8'h20, 8'h03, 8'h0F, 8'h00},
    '{8'h30, 8'h10, 8'h0C, 2'b00, 8'h10, 8'h0C, 8'hCF, 8'h00},
    '{8'h30, 8'h0C, 8'h05, 2'b00, 8'h0C, 8'h06, 8'hCF, 8'h00},
    '{8'h30, 8'h14, 8'h0F, 2'b00, 8'h14, 8'h0F, 8'hCF, 8'h70},
    '{8'h30, 8'h08, 8'hFF, 2'b00, 8'h08, 8'h0F, 8'hCF, 8'h73}};

  dgp_gpio #(.PINS(4)) u_dgp_gpio (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_req, .pin_i, .pin_o, .pin_oe,
    .pullup_en, .ppg0_trigger_input, .adc_trigger_input, .ext_irq_in);
  dgp_pins_model u_dgp_pins_model (.aclk, .pin_o, .pin_oe, .pullup_en, .ext_val, .ext_en, .pin_i);

  initial forever #2.5 aclk = ~aclk;

  task automatic chk(input string nm, input logic [34:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bus tasks hold every request until its own ready edge; only the watchdog ends a hang.
  // A nonzero lag raises the response ready late, so the slave must hold its answer.
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er, input int lag = 0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == lag) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk("bresp", {s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a, rv, input int lag = 0);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == lag) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    chk("rdata", {s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {3'h4, 24'h00_0000, rv});
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      ext_en <= rows[i].en;
      wr(rows[i].wa, rows[i].wd, rows[i].er);
      rd(rows[i].ra, rows[i].rv);
      chk("pin_oe", pin_oe, rows[i].oe);
      chk("pullup_en", pullup_en, rows[i].pu);
    end
    // ****************************************************************
    // Late ready, lane strobe, standby, reset again
    // ****************************************************************
    chk("pin_o", pin_o, 8'h53);
    rd(8'h24, 8'h05, 3);
    s_axi_wstrb <= 4'hE;
    wr(8'h00, 8'h0C, 2'b00, 3);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 8'h03);
    wr(8'h18, 8'h01, 2'b00);
    wr(8'h1C, 8'h32, 2'b00);
    standby_req <= 1'b1;
    // The floated trigger pin rises through the pull-up and then the full sync path.
    repeat (6) @(posedge aclk);
    chk("pin_oe", pin_oe, 8'h00);
    chk("trigger", {ppg0_trigger_input, adc_trigger_input}, 2'b11);
    chk("ext_irq_in", ext_irq_in, 4'h2);
    wr(8'h1C, 8'h12, 2'b00);
    repeat (4) @(posedge aclk);
    chk("trigger", {ppg0_trigger_input, adc_trigger_input}, 2'b00);
    standby_req <= 1'b0;
    wr(8'h18, 8'h00, 2'b00);
    standby_req <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("pin_oe", pin_oe, 8'hCF);
    rd(8'h00, 8'h03);
    standby_req <= 1'b0;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h00);
    chk("pin_oe", pin_oe, 8'h00);
    conclude();
  end
endmodule // dgp_gpio_test

// [dv/dgp_pins_model.sv]
`timescale 1ns/1ps
module dgp_pins_model (
  input  wire logic       aclk,
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_i
);
  logic float_q = 1'b0;

  // An open pin wanders, so no stale level can be mistaken for a real one.
  always @(posedge aclk) float_q <= ~float_q;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_i[i] = pin_o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pullup_en[i]) pin_i[i] = 1'b1;
      else pin_i[i] = float_q ^ i[0];
    end
  end
endmodule // dgp_pins_model
